// File: verilog/sardma_consts.svh
// Purpose: constants of the ready-handshake channel sequencer
// Assumes: 50 MHz pclk
// Notes: offsets are byte addresses on APB
`ifndef SARDMA_CONSTS_SVH
`define SARDMA_CONSTS_SVH
`define SARDMA_OFS_CTRL 12'h000
`define SARDMA_OFS_MADDR 12'h004
`define SARDMA_OFS_DADDR 12'h008
`define SARDMA_OFS_STAT 12'h00C
`define SARDMA_OFS_DATA 12'h010
`define SARDMA_CTRL_RST 32'h0000_0000
`define SARDMA_F_START 0
`define SARDMA_F_DIR 1
`define SARDMA_F_DUAL 2
`define SARDMA_F_PORT16 3
`define SARDMA_F_OPSZ 4
`define SARDMA_F_REQUEST_GENERATION_FIELD 6
`define SARDMA_F_MCNT 8
`define SARDMA_F_DCNT 10
`define SARDMA_F_PACK 12
`define SARDMA_RATE_CYC 8'd16
`endif

// File: verilog/sardma_pkg.sv
// Purpose: types of the ready-handshake channel sequencer
// Assumes: nothing
// Notes: operand and count encodings
package sardma_pkg;
    typedef enum logic [1:0] {
        SARDMA_BYTE = 2'b00,
        SARDMA_WORD = 2'b01,
        SARDMA_LONG = 2'b10
    } sardma_size_type;
    typedef enum logic [1:0] {
        SARDMA_HOLD = 2'b00,
        SARDMA_UP = 2'b01,
        SARDMA_DOWN = 2'b10
    } sardma_count_type;
    typedef struct packed {
        logic lower_byte_strobe_n;
        logic upper_byte_strobe_n;
        logic transfer_complete_strobe_n;
        logic grant_n;
    } sardma_strobe_type;
endpackage

// File: verilog/sardma_step.sv
// Purpose: address step for one operand
// Assumes: sizes checked legal upstream
// Notes: pure combinational
`timescale 1ns/1ns
module sardma_step (
    input wire logic dual, // Dual addressing
    input wire logic port16, // Peripheral 16-bit port
    input wire logic pack, // Packing done
    input wire sardma_pkg::sardma_size_type opsz, // Operand size
    input wire sardma_pkg::sardma_count_type cnt, // Count direction
    output logic [23:0] step // Signed step, two's complement
);
    import sardma_pkg::*;
    logic [23:0] mag;
    // Single: step per operand; dual: by table
    always_comb begin
        mag = 24'h00_0000;
        if (!dual) begin
            mag = (opsz == SARDMA_WORD) ? 24'h00_0002 : 24'h00_0001;
        end else if (port16) begin
            if (opsz == SARDMA_BYTE) begin
                mag = pack ? 24'h00_0002 : 24'h00_0001;
            end else begin
                mag = (opsz == SARDMA_LONG) ? 24'h00_0004 : 24'h00_0002;
            end
        end else begin
            case (opsz)
                SARDMA_BYTE: mag = 24'h00_0002;
                SARDMA_WORD: mag = 24'h00_0004;
                default: mag = 24'h00_0008;
            endcase
        end
        case (cnt)
            SARDMA_UP: step = mag;
            SARDMA_DOWN: step = 24'(~mag + 24'h00_0001);
            default: step = 24'h00_0000;
        endcase
    end
endmodule // sardma_step

// File: verilog/sardma_top.sv
// Purpose: single-channel ready-handshake transfer sequencer with APB registers
// Assumes: pclk is the bus clock; half-clock events use a falling-edge retime
// Notes: one operand per start; dual mode alternates memory and device cycles per part
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "sardma_consts.svh"
module sardma_top (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [11:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic req_n, // Peripheral request, pin
    input wire logic peripheral_control_line, // Ready from peripheral, active low
    input wire logic memory_transfer_done_n, // Memory acknowledge, pin
    output logic bus_req, // Bus request to arbiter
    input wire logic bus_grant, // Bus granted, same clock
    output sardma_pkg::sardma_strobe_type strobes, // Handshake strobes
    output logic [23:0] addr, // Cycle address
    output logic rd_nwr // High: read cycle; a memory read except in dual device cycles
);
    import sardma_pkg::*;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_BUS = 3'b001, ST_C3 = 3'b011, ST_C5 = 3'b010,
        ST_C7 = 3'b110, ST_C8 = 3'b111
    } sardma_state_type;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] rq_s, rdy_s, dn_s;
    logic req_r, rdy_r, dn_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rq_s <= 3'b111;
            rdy_s <= 3'b111;
            dn_s <= 3'b111;
        end else begin
            rq_s <= {rq_s[1:0], req_n};
            rdy_s <= {rdy_s[1:0], peripheral_control_line};
            dn_s <= {dn_s[1:0], memory_transfer_done_n};
        end
    end
    // Level counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_r <= 1'b0;
            rdy_r <= 1'b0;
            dn_r <= 1'b0;
        end else begin
            if (rq_s[1] == rq_s[2]) req_r <= ~rq_s[2];
            if (rdy_s[1] == rdy_s[2]) rdy_r <= ~rdy_s[2];
            if (dn_s[1] == dn_s[2]) dn_r <= ~dn_s[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0] ctrl_r, maddr_r, daddr_r, hold_r;
    logic [15:0] done_cnt_r;
    logic cfg_err_r;
    wire logic start = ctrl_r[`SARDMA_F_START];
    wire logic m2p = ctrl_r[`SARDMA_F_DIR]; // Memory to peripheral
    wire logic dual = ctrl_r[`SARDMA_F_DUAL];
    wire logic port16 = ctrl_r[`SARDMA_F_PORT16];
    wire sardma_size_type opsz = sardma_size_type'(ctrl_r[`SARDMA_F_OPSZ +: 2]);
    wire logic [1:0] request_generation_field = ctrl_r[`SARDMA_F_REQUEST_GENERATION_FIELD +: 2];
    wire sardma_count_type mcnt = sardma_count_type'(ctrl_r[`SARDMA_F_MCNT +: 2]);
    wire sardma_count_type dcnt = sardma_count_type'(ctrl_r[`SARDMA_F_DCNT +: 2]);
    // merging never with a holding address
    wire logic pack = ctrl_r[`SARDMA_F_PACK] && dual && (opsz == SARDMA_BYTE)
        && (dcnt != SARDMA_HOLD) && (mcnt != SARDMA_HOLD);
    wire logic bad_single = !dual && (port16 ? (opsz != SARDMA_WORD) : (opsz != SARDMA_BYTE));
    // no byte on 16-bit port with external requests
    wire logic bad_dual = dual && port16 && (opsz == SARDMA_BYTE) && request_generation_field[1];
    wire logic cfg_bad = bad_single || bad_dual || (opsz == 2'b11) || (mcnt == 2'b11)
        || (dcnt == 2'b11);
    wire logic apb_acc = psel && penable;
    wire logic apb_wr = apb_acc && pwrite;
    wire logic hit = (paddr == `SARDMA_OFS_CTRL) || (paddr == `SARDMA_OFS_MADDR)
        || (paddr == `SARDMA_OFS_DADDR) || (paddr == `SARDMA_OFS_STAT)
        || (paddr == `SARDMA_OFS_DATA);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state
    sardma_state_type st_r, st_nxt;
    logic [2:0] part_r, nparts; // Part index and count
    logic phase_dev_r; // Dual: device half of a part pair
    logic first_r; // First operand of the run
    logic [7:0] rate_r;
    logic active_r, busy_r;
    logic [23:0] mstep, dstep;
    sardma_step u_mstep (.dual(1'b0), .port16(port16), .pack(1'b0),
        .opsz(dual ? (pack ? SARDMA_WORD : opsz) : opsz), .cnt(mcnt), .step(mstep));
    sardma_step u_dstep (.dual(dual), .port16(port16), .pack(pack), .opsz(opsz),
        .cnt(dcnt), .step(dstep));
    // parts = operand over port size; memory is 16-bit
    always_comb begin
        nparts = 3'd1;
        if (dual && !port16) begin
            nparts = (opsz == SARDMA_LONG) ? 3'd4 : ((opsz == SARDMA_WORD) ? 3'd2 : 3'd1);
        end else if (dual && opsz == SARDMA_LONG) begin
            nparts = 3'd2;
        end
    end
    wire logic auto_ok = (request_generation_field == 2'b01) || ((request_generation_field == 2'b00) && (rate_r == 8'h00))
        || ((request_generation_field == 2'b11) && first_r);
    wire logic want = active_r && (auto_ok || (request_generation_field[1] && req_r));
    // Handshake applies to the device-side cycle only
    wire logic hs_cycle = !dual || phase_dev_r;
    wire logic c3_go = !m2p ? (rdy_r || !hs_cycle) : 1'b1;
    wire logic c5_go = m2p ? (dn_r && (rdy_r || !hs_cycle)) : dn_r;
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: if (want) st_nxt = ST_BUS;
            ST_BUS: if (bus_grant) st_nxt = ST_C3;
            // peripheral to memory waits at clock 3 for ready; memory to peripheral goes on
            ST_C3: if (c3_go) st_nxt = ST_C5;
            // wait at clock 5; end on memory done
            ST_C5: if (c5_go) st_nxt = ST_C7;
            // no waits gives C3, C5, C7, C8
            ST_C7: st_nxt = ST_C8;
            ST_C8: st_nxt = ST_IDLE;
            default: st_nxt = ST_IDLE;
        endcase
    end
    wire logic cyc_end = (st_r == ST_C8);
    wire logic last_part = (part_r == 3'(nparts - 3'd1));
    // dual alternates memory and device cycle per part
    wire logic op_end = cyc_end && (!dual || (phase_dev_r && last_part));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end
    // Part bookkeeping and rate limiter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            part_r <= 3'd0;
            phase_dev_r <= 1'b0;
            first_r <= 1'b1;
            rate_r <= 8'h00;
        end else begin
            if (cyc_end && dual) phase_dev_r <= ~phase_dev_r;
            if (cyc_end && dual && phase_dev_r) part_r <= last_part ? 3'd0 : 3'(part_r + 3'd1);
            if (op_end) first_r <= 1'b0;
            else if (start) first_r <= 1'b1;
            if (op_end) rate_r <= `SARDMA_RATE_CYC;
            else if (rate_r != 8'h00) rate_r <= 8'(rate_r - 8'h01);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB registers and addresses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `SARDMA_CTRL_RST;
            maddr_r <= 32'h0000_0000;
            daddr_r <= 32'h0000_0000;
            hold_r <= 32'h0000_0000;
            active_r <= 1'b0;
            cfg_err_r <= 1'b0;
            done_cnt_r <= 16'h0000;
        end else begin
            if (apb_wr && paddr == `SARDMA_OFS_CTRL) ctrl_r <= pwdata;
            else ctrl_r[`SARDMA_F_START] <= 1'b0;
            if (apb_wr && paddr == `SARDMA_OFS_DATA) hold_r <= pwdata;
            // Error wins: bad setups never run
            if (start && !active_r) begin
                active_r <= !cfg_bad;
                cfg_err_r <= cfg_bad;
            end else if (op_end) begin
                active_r <= 1'b0;
                done_cnt_r <= 16'(done_cnt_r + 16'h0001);
            end
            if (apb_wr && paddr == `SARDMA_OFS_MADDR) maddr_r <= pwdata;
            else if (cyc_end && (!dual || !phase_dev_r) && (!dual || last_part || 1'b1))
                maddr_r <= {8'h00, 24'(maddr_r[23:0] + (dual ? mstep : mstep))};
            if (apb_wr && paddr == `SARDMA_OFS_DADDR) daddr_r <= pwdata;
            else if (op_end && dual) daddr_r <= {8'h00, 24'(daddr_r[23:0] + dstep)};
        end
    end
    wire logic [23:0] dev_part_addr = 24'(daddr_r[23:0] + {20'h0_0000, part_r, 1'b0});
    wire logic [31:0] stat_w = {14'h0000, done_cnt_r, cfg_err_r, active_r};
    wire logic [31:0] rd_mux = (paddr == `SARDMA_OFS_CTRL) ? ctrl_r :
        (paddr == `SARDMA_OFS_MADDR) ? maddr_r : (paddr == `SARDMA_OFS_DADDR) ? daddr_r :
        (paddr == `SARDMA_OFS_STAT) ? stat_w : hold_r;
    // Zero-wait slave, error on unmapped offsets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata <= (psel && !penable && hit) ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs: grant and strobes
    logic ds_rise, ds_fall_n, dtc_r, grant_n_r;
    logic upper_n, lower_n;
    wire logic in_cyc = (st_r == ST_C3) || (st_r == ST_C5) || (st_r == ST_C7) || (st_r == ST_C8);
    // complete strobe from clock 7, memory to peripheral handshake cycles only; strobes drop a half clock after
    wire logic dtc_nxt = (st_nxt == ST_C7) && m2p && hs_cycle;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_req <= 1'b0;
            grant_n_r <= 1'b1;
            addr <= 24'h00_0000;
            rd_nwr <= 1'b1;
            dtc_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            bus_req <= (st_nxt != ST_IDLE) && (st_nxt != ST_C8);
            // grant held through waits until the end
            grant_n_r <= !(((st_nxt == ST_C3) || (st_nxt == ST_C5) || (st_nxt == ST_C7))
                && hs_cycle);
            addr <= (dual && phase_dev_r) ? dev_part_addr : maddr_r[23:0];
            rd_nwr <= dual ? (m2p ^ phase_dev_r) : m2p;
            dtc_r <= dtc_nxt;
            busy_r <= in_cyc;
        end
    end
    // byte strobes on the falling edge of clock 5 for peripheral to memory, clock 3 for memory to peripheral
    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            ds_rise <= 1'b0;
        end else begin
            ds_rise <= (st_r == ST_C5) || (st_r == ST_C7) || (m2p && (st_r == ST_C3));
        end
    end
    assign ds_fall_n = !ds_rise;
    wire logic byte_hi = !port16 && !dual && addr[0] == 1'b0;
    assign upper_n = ds_fall_n || (!port16 && !byte_hi && !dual);
    assign lower_n = ds_fall_n || (!port16 && byte_hi);
    // One driver for the whole strobe bundle
    assign strobes = '{lower_byte_strobe_n: lower_n, upper_byte_strobe_n: upper_n,
        transfer_complete_strobe_n: !dtc_r, grant_n: grant_n_r};

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_GRANT_HELD: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == ST_C5) && !c5_go && hs_cycle |=> !strobes.grant_n)
        else $error("grant dropped in wait");
    AST_M2P_BOTH: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == ST_C5) && m2p && hs_cycle && !(dn_r && rdy_r) |=> st_r == ST_C5)
        else $error("m2p advanced without both");
    AST_P2M_RDY: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == ST_C3) && !m2p && hs_cycle && !rdy_r |=> st_r == ST_C3)
        else $error("p2m advanced without ready");
    AST_DTC_C7: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == ST_C5) && c5_go && m2p && hs_cycle |=> strobes.transfer_complete_strobe_n == 1'b0)
        else $error("complete strobe missing");
    AST_FOUR: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == ST_BUS) && bus_grant ##1 (m2p && c3_go) ##1 c5_go |=> ##1 st_r == ST_C8)
        else $error("cycle not four clocks");
    AST_P2M_END: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == ST_C5) && !m2p && !dn_r |=> st_r == ST_C5)
        else $error("p2m ended without done");
    AST_CFG: assert property (@(posedge pclk) disable iff (!presetn)
        start && !active_r && bad_single |=> !active_r && cfg_err_r)
        else $error("illegal single accepted");
    AST_DUAL16: assert property (@(posedge pclk) disable iff (!presetn)
        start && !active_r && bad_dual |=> !active_r)
        else $error("illegal dual accepted");
    COV_M2P: cover property (@(posedge pclk) disable iff (!presetn) op_end && m2p);
    COV_P2M: cover property (@(posedge pclk) disable iff (!presetn) op_end && !m2p);
    COV_WAIT: cover property (@(posedge pclk) disable iff (!presetn) (st_r == ST_C5) [*3]);

    // Strobe shape and sequencing checks
    AST_DTC_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        !strobes.transfer_complete_strobe_n |=> strobes.transfer_complete_strobe_n)
        else $error("complete strobe longer than one clock");
    AST_DS_AT_DTC: assert property (@(posedge pclk) disable iff (!presetn)
        !strobes.transfer_complete_strobe_n |-> !(lower_n && upper_n))
        else $error("byte strobes dropped before complete strobe");
    AST_P2M_NODS: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == ST_C3) && !m2p |-> !ds_rise)
        else $error("p2m byte strobes before ready");
    AST_P2M_DS: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == ST_C5) |-> ds_rise)
        else $error("byte strobes missing in clock 5");
    AST_GRANT_C3: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == ST_C3) && hs_cycle |-> !strobes.grant_n)
        else $error("grant missing at clock 3");
    AST_GRANT_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == ST_IDLE) |-> strobes.grant_n)
        else $error("grant active while idle");
    AST_DUAL_ALT: assert property (@(posedge pclk) disable iff (!presetn)
        cyc_end && dual |=> phase_dev_r != $past(phase_dev_r))
        else $error("dual cycles did not alternate");
    AST_SINGLE_UP: assert property (@(posedge pclk) disable iff (!presetn)
        cyc_end && !dual && (mcnt == SARDMA_UP) && !(apb_wr && paddr == `SARDMA_OFS_MADDR)
        |=> maddr_r[23:0] == 24'($past(maddr_r[23:0])
        + ((opsz == SARDMA_WORD) ? 24'h00_0002 : 24'h00_0001)))
        else $error("single memory step wrong");
    COV_DUAL: cover property (@(posedge pclk) disable iff (!presetn) op_end && dual);
    COV_PACK: cover property (@(posedge pclk) disable iff (!presetn) op_end && pack);
endmodule // sardma_top

// File: bench/sardma_partner.sv
// Purpose: peripheral and memory responder for the sequencer bench
// Assumes: ready and done lines pull high whenever they are released
// Notes: response delays come from the bench, so waits can be stretched
`timescale 1ns/1ns
module sardma_partner (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic bus_req, // Bus request from sequencer
    input wire sardma_pkg::sardma_strobe_type strobes, // Handshake strobes
    input wire logic [7:0] rdy_dly, // Grant to ready, cycles
    input wire logic [7:0] done_dly, // Bus grant to memory done, cycles
    output logic bus_grant, // Arbiter grant
    output logic peripheral_control_line, // Ready, active low
    output logic memory_transfer_done_n // Memory acknowledge, active low
);
    import sardma_pkg::*;
    logic [7:0] rdy_cnt_r;
    logic [7:0] done_cnt_r;
    logic grant_q_r;
    logic part_end;
    ////////////////////////////////////////////////////////////////////////////////
    // Part ends when grant rises; memory answer restarts for the next part
    assign part_end = strobes.grant_n && !grant_q_r;
    // ready marks data
    // Ready only inside the grant, so the released line reads high
    assign peripheral_control_line = !(!strobes.grant_n && rdy_cnt_r >= rdy_dly);
    assign memory_transfer_done_n = !(bus_grant && !part_end && done_cnt_r >= done_dly);
    // Counters restart whenever their qualifier drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_grant <= 1'b0;
            grant_q_r <= 1'b1;
            rdy_cnt_r <= 8'h00;
            done_cnt_r <= 8'h00;
        end else begin
            bus_grant <= bus_req;
            grant_q_r <= strobes.grant_n;
            rdy_cnt_r <= strobes.grant_n ? 8'h00 : rdy_cnt_r + 8'h01;
            done_cnt_r <= (!bus_grant || part_end) ? 8'h00 : done_cnt_r + 8'h01;
        end
    end
endmodule // sardma_partner

// File: bench/single_address_ready_dma_tb.sv
// Purpose: self-checking bench for the ready-handshake sequencer
// Assumes: one operand per start, status polled over APB
// Notes: wait lengths judged by differences, so sync latency cancels out
`timescale 1ns/1ns
`include "sardma_consts.svh"
module single_address_ready_dma_tb;
    import sardma_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, req_n, prdy_n, mdone_n, bus_req, bus_grant, rd_nwr, cyc_rd;
    logic [7:0] rdy_dly = 8'h01;
    logic [7:0] done_dly = 8'h01;
    logic [23:0] addr, cyc_addr;
    sardma_strobe_type strobes;
    int mismatches = 0;
    int n_tests = 0;
    initial req_n = 1'b1;
    always #10 pclk = ~pclk;
    sardma_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req_n(req_n), .peripheral_control_line(prdy_n),
        .memory_transfer_done_n(mdone_n), .bus_req(bus_req), .bus_grant(bus_grant),
        .strobes(strobes), .addr(addr), .rd_nwr(rd_nwr));
    sardma_partner u_partner (.pclk(pclk), .presetn(presetn), .bus_req(bus_req),
        .strobes(strobes), .rdy_dly(rdy_dly), .done_dly(done_dly), .bus_grant(bus_grant),
        .peripheral_control_line(prdy_n), .memory_transfer_done_n(mdone_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (mismatches == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check(nm, exp, r);
    endtask
    // Poll until the active flag drops, bounded
    task automatic wait_idle;
        logic [31:0] r;
        logic e;
        int n = 0;
        do begin
            apb(1'b0, `SARDMA_OFS_STAT, 32'h0000_0000, r, e);
            n++;
        end while (r[0] !== 1'b0 && n < 100);
        check("idle", 32'h0000_0000, {31'h0, r[0]});
    endtask
    // Watches one grant; counts length, complete strobes and strobe faults
    task automatic run_cycle(input logic p2m, output int len, output int transfer_complete_strobe, output int bad);
        int n = 0;
        len = 0;
        transfer_complete_strobe = 0;
        bad = 0;
        while (strobes.grant_n !== 1'b0 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        cyc_addr = addr;
        cyc_rd = rd_nwr;
        while (strobes.grant_n === 1'b0 && len < 200) begin
            if (strobes.transfer_complete_strobe_n === 1'b0) begin
                transfer_complete_strobe++;
                if (strobes.lower_byte_strobe_n & strobes.upper_byte_strobe_n) bad++;
            end
            if (p2m && prdy_n && !(strobes.lower_byte_strobe_n & strobes.upper_byte_strobe_n))
                bad++;
            @(posedge pclk);
            len++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        rchk(`SARDMA_OFS_CTRL, `SARDMA_CTRL_RST, "ctrl reset");
        rchk(`SARDMA_OFS_MADDR, 32'h0000_0000, "maddr reset");
        apb(1'b0, 12'h020, 32'h0000_0000, r, e);
        check("unmapped err", 32'h0000_0001, {31'h0, e});
    endtask
    task automatic t_m2p;
        int l6, l10, d, b;
        wr(`SARDMA_OFS_MADDR, 32'h0000_0100);
        rdy_dly <= 8'h06;
        wr(`SARDMA_OFS_CTRL, 32'h0000_0143);
        run_cycle(1'b0, l6, d, b);
        check("m2p dtc", 32'h0000_0001, d);
        check("m2p dtc strobe", 32'h0000_0000, b);
        check("m2p dir", 32'h0000_0001, {31'h0, cyc_rd});
        check("m2p addr", 32'h0000_0100, {8'h00, cyc_addr});
        wait_idle();
        rdy_dly <= 8'h0a;
        wr(`SARDMA_OFS_CTRL, 32'h0000_0143);
        run_cycle(1'b0, l10, d, b);
        check("m2p wait step", 32'h0000_0004, l10 - l6);
        wait_idle();
        rchk(`SARDMA_OFS_MADDR, 32'h0000_0102, "m2p maddr");
    endtask
    // peripheral to memory, word, counting down
    task automatic t_p2m;
        int l, d, b;
        wr(`SARDMA_OFS_MADDR, 32'h0000_0200);
        rdy_dly <= 8'h08;
        wr(`SARDMA_OFS_CTRL, 32'h0000_0259);
        run_cycle(1'b1, l, d, b);
        check("p2m strobe early", 32'h0000_0000, b);
        check("p2m dir", 32'h0000_0000, {31'h0, cyc_rd});
        wait_idle();
        rchk(`SARDMA_OFS_MADDR, 32'h0000_01fe, "p2m maddr");
    endtask
    // external request waits for the request pin
    task automatic t_ext;
        int l, d, b;
        rdy_dly <= 8'h01;
        wr(`SARDMA_OFS_CTRL, 32'h0000_0083);
        repeat (20) @(posedge pclk);
        check("ext idle req", 32'h0000_0000, {31'h0, bus_req});
        req_n <= 1'b0;
        run_cycle(1'b0, l, d, b);
        req_n <= 1'b1;
        check("ext served", 32'h0000_0001, d);
        wait_idle();
    endtask
    task automatic t_table;
        logic [31:0] ctl [10] = '{32'h0000_0407, 32'h0000_081f, 32'h0000_0425,
            32'h0000_042d, 32'h0000_040d, 32'h0000_150d, 32'h0000_0011, 32'h0000_0009,
            32'h0000_008d, 32'h0000_00cd};
        logic [31:0] st [6] = '{32'h0000_0102, 32'h0000_00fe, 32'h0000_0108,
            32'h0000_0104, 32'h0000_0101, 32'h0000_0102};
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 10; i++) begin
            wr(`SARDMA_OFS_DADDR, 32'h0000_0100);
            wr(`SARDMA_OFS_CTRL, ctl[i]);
            if (i >= 6) begin
                repeat (10) @(posedge pclk);
                check("cfg no bus", 32'h0000_0000, {31'h0, bus_req});
                apb(1'b0, `SARDMA_OFS_STAT, 32'h0000_0000, r, e);
                check("cfg err", 32'h0000_0002, {30'h0, r[1:0]});
            end else begin
                wait_idle();
                rchk(`SARDMA_OFS_DADDR, st[i], "dual daddr");
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1_000_000;
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_m2p();
        t_p2m();
        t_ext();
        t_table();
        wrap_up();
    end
endmodule // single_address_ready_dma_tb
